// ---- rtl/dai_decoder.sv ----
// decoded control-store addressing and i/o request logic
`timescale 1ns/1ps
`default_nettype none

// How it works
// - each 16-bit instruction maps to a 9-bit control-store address via the tables
// - two decoder tables, 16 words of 16 bits each
// - fixed tables by default; a control bit selects loadable tables instead
// - primary table indexed by instruction bits 15..12
// - secondary table indexed by instruction bits 11..8
// - decoded path needs test and source fields zero and group bit 2 set
// - a pending enabled interrupt overrides decoding, interrupt path used
// - mode 11x0 inhibits decoding; without interrupt, field-select path used
// - low nine primary bits always form the address base
// - secondary bits 8..4 or-ed in when primary bit 12 or 15 is zero
// - secondary bits 3..0 or-ed in when primary bit 10 set, 12 or 15 zero
// - instruction bits 7..4 or-ed in on primary 14 zero or alt condition
// - instruction bits 3..0 or-ed in on primary 13 zero or alt condition
// - primary 0 and secondary 9 set: address bit 2 takes bit 3, not 6
// - leftover table bits go out as class signals
// - source zero and mode 111x raise an i/o request
// - mode 1110 requests i/o and suppresses decoding together
// - i/o start: high, mid, low fields, branch top bit, bit 0 zero
// - source zero, mode 0010 stalls until the i/o sequence is done
// - a request while the sequencer is busy stalls until it finishes
module dai_decoder
   import dai_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire dai_apb_req_t apb_req,
   output var dai_apb_rsp_t apb_rsp,
   input wire logic [15:0] instr_buf,
   input wire dai_uinstr_t uinstr,
   input wire logic uinstr_valid,
   input wire logic int_pending,
   input wire logic io_idle,
   input wire logic sequence_done_flag,
   output logic [8:0] decoded_addr,
   output logic [2:0] addr_path,
   output logic addr_valid,
   output logic io_request,
   output logic [7:0] io_start_addr,
   output logic stall,
   output logic [6:0] primary_class,
   output logic [6:0] secondary_class
);

   // ==========================================================
   // address formation
   function automatic logic [8:0] form_addr(
      input logic [15:0] pri,
      input logic [15:0] sec,
      input logic [15:0] ib
   );
      logic hi_gate;
      logic alt;
      logic [3:0] nib;
      logic [8:0] a;
      hi_gate = !pri[PRI_HI_GATE_A] || !pri[PRI_HI_GATE_B];
      alt = !pri[PRI_HI_GATE_B] && sec[SEC_ALT];
      nib = ib[7:4];
      a = pri[8:0];
      if (hi_gate)
         a[8:4] = a[8:4] | sec[8:4];
      if (hi_gate && pri[PRI_LO_GATE])
         a[3:0] = a[3:0] | sec[3:0];
      if (pri[PRI_SWAP] && sec[SEC_SWAP])
         nib[2] = ib[3];
      if (!pri[PRI_NIB_HI_N] || alt)
         a[3:0] = a[3:0] | nib;
      if (!pri[PRI_NIB_LO_N] || alt)
         a[3:0] = a[3:0] | ib[3:0];
      return a;
   endfunction

   dai_regs_t r_q;
   dai_regs_t r_d;
   logic [15:0] pri_w;
   logic [15:0] sec_w;
   logic [8:0] addr_w;
   logic [2:0] path_w;
   logic io_req_w;
   logic wait_done_w;
   logic [7:0] start_w;

   // table lookup; the loadable copy only matters once selected
   always_comb
   begin
      if (r_q.use_wr)
      begin
         pri_w = r_q.pri_ram[instr_buf[15:12]];
         sec_w = r_q.sec_ram[instr_buf[11:8]];
      end
      else
      begin
         pri_w = DAI_PRI_ROM[instr_buf[15:12]];
         sec_w = DAI_SEC_ROM[instr_buf[11:8]];
      end
   end

   // combinational address, registered at microcycle end
   assign addr_w = form_addr(pri_w, sec_w, instr_buf);

   // path choice with fixed priority
   always_comb
   begin
      if (int_pending)
         path_w = DAI_PATH_INT;
      else if (uinstr.request_mode_field[3:2] == 2'b11 &&
               !uinstr.request_mode_field[0])
         path_w = DAI_PATH_FIELD;
      else if (uinstr.sequence_test_field == DAI_TEST_NONE &&
               uinstr.source_select_field == DAI_SRC_NONE &&
               uinstr.group_function_field[2])
         path_w = DAI_PATH_DEC;
      else
         path_w = DAI_PATH_FIELD;
   end

   // i/o request and wait decode
   assign io_req_w = uinstr.source_select_field == DAI_SRC_NONE &&
                     uinstr.request_mode_field[3:1] == 3'b111;
   assign wait_done_w = uinstr.source_select_field == DAI_SRC_NONE &&
                        uinstr.request_mode_field == DAI_MODE_WAIT_DONE;
   assign start_w = {uinstr.io_start_high_field, uinstr.io_start_mid_field,
                     uinstr.io_start_low_field,
                     uinstr.branch_field_top_bit, 1'b0};

   // ==========================================================
   // next state: sequencing plus apb slave
   always_comb
   begin
      logic acc;
      logic [3:0] idx;
      r_d = r_q;
      acc = apb_req.psel && apb_req.penable && !r_q.pready;
      idx = apb_req.paddr[5:2];
      r_d.addr_valid = 1'b0;
      r_d.io_req = 1'b0;
      unique case (r_q.fsm)
         ST_RUN:
         begin
            if (uinstr_valid)
            begin
               r_d.addr = addr_w;
               r_d.path = path_w;
               r_d.pri_class = pri_w[15:9];
               r_d.sec_class = sec_w[15:9];
               r_d.io_start = start_w;
               if (wait_done_w && !io_idle)
               begin
                  r_d.fsm = ST_WAIT_DONE;
                  r_d.stall = 1'b1;
               end
               else if (io_req_w && !io_idle)
               begin
                  r_d.fsm = ST_WAIT_IDLE;
                  r_d.stall = 1'b1;
               end
               else
               begin
                  r_d.io_req = io_req_w;
                  r_d.addr_valid = 1'b1;
               end
            end
         end
         ST_WAIT_DONE:
         begin
            // done pulse or idle level both end the wait
            if (sequence_done_flag || io_idle)
            begin
               r_d.fsm = ST_RUN;
               r_d.stall = 1'b0;
               r_d.addr_valid = 1'b1;
            end
         end
         ST_WAIT_IDLE:
         begin
            if (io_idle)
            begin
               r_d.fsm = ST_RUN;
               r_d.stall = 1'b0;
               r_d.io_req = 1'b1;
               r_d.addr_valid = 1'b1;
            end
         end
      endcase

      // one wait state on every apb access
      r_d.pready = acc;
      r_d.pslverr = 1'b0;
      if (acc)
      begin
         r_d.prdata = 32'h0000_0000;
         if (apb_req.paddr[1:0] != 2'h0)
            r_d.pslverr = 1'b1;
         else if (apb_req.paddr[7:6] == DAI_RGN_PRI)
            r_d.prdata[15:0] = r_q.pri_ram[idx];
         else if (apb_req.paddr[7:6] == DAI_RGN_SEC)
            r_d.prdata[15:0] = r_q.sec_ram[idx];
         else if (apb_req.paddr == DAI_OFS_CTRL)
            r_d.prdata[DAI_CTRL_USE_WR] = r_q.use_wr;
         else if (apb_req.paddr == DAI_OFS_STATUS)
            r_d.prdata[6:0] = {r_q.fsm, r_q.path, r_q.stall};
         else if (apb_req.paddr == DAI_OFS_LAST)
            r_d.prdata[8:0] = r_q.addr;
         else
            r_d.pslverr = 1'b1;
      end

      // a write lands only at the edge where the master sees pready high
      if (apb_req.psel && apb_req.penable && r_q.pready && !r_q.pslverr &&
          apb_req.pwrite)
      begin
         if (apb_req.paddr[7:6] == DAI_RGN_PRI)
            r_d.pri_ram[idx] = apb_req.pwdata[15:0];
         else if (apb_req.paddr[7:6] == DAI_RGN_SEC)
            r_d.sec_ram[idx] = apb_req.pwdata[15:0];
         else if (apb_req.paddr == DAI_OFS_CTRL)
            r_d.use_wr = apb_req.pwdata[DAI_CTRL_USE_WR];
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         r_q <= DAI_REGS_RST;
      else
         r_q <= r_d;
   end

   // ==========================================================
   // outputs straight from the state register
   assign decoded_addr = r_q.addr;
   assign addr_path = r_q.path;
   assign addr_valid = r_q.addr_valid;
   assign io_request = r_q.io_req;
   assign io_start_addr = r_q.io_start;
   assign stall = r_q.stall;
   assign primary_class = r_q.pri_class;
   assign secondary_class = r_q.sec_class;
   assign apb_rsp.prdata = r_q.prdata;
   assign apb_rsp.pready = r_q.pready;
   assign apb_rsp.pslverr = r_q.pslverr;

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   logic take_w;
   logic [8:0] base_w;
   logic [4:0] pri_hi_w;
   logic hi_gate_w;
   logic [6:0] pri_cls_w;
   assign take_w = r_q.fsm == ST_RUN && uinstr_valid;
   assign base_w = pri_w[8:0];
   assign pri_hi_w = pri_w[8:4];
   assign hi_gate_w = !pri_w[PRI_HI_GATE_A] || !pri_w[PRI_HI_GATE_B];
   assign pri_cls_w = pri_w[15:9];

   a_int_path_wins: assert property (take_w && int_pending |=>
      addr_path == DAI_PATH_INT) else $error("interrupt path not taken");
   a_decode_path_sel: assert property (take_w && !int_pending &&
      uinstr.sequence_test_field == DAI_TEST_NONE &&
      uinstr.source_select_field == DAI_SRC_NONE &&
      uinstr.group_function_field[2] &&
      !(uinstr.request_mode_field[3:2] == 2'b11 &&
        !uinstr.request_mode_field[0])
      |=> addr_path == DAI_PATH_DEC) else $error("decoded path missed");
   a_mode_inhibit: assert property (take_w && !int_pending &&
      uinstr.request_mode_field[3:2] == 2'b11 &&
      !uinstr.request_mode_field[0]
      |=> addr_path == DAI_PATH_FIELD) else $error("inhibit ignored");
   a_base_kept: assert property (take_w |=>
      (decoded_addr & $past(base_w)) == $past(base_w))
      else $error("base bits lost");
   a_high_bits_pure: assert property (take_w && !hi_gate_w |=>
      decoded_addr[8:4] == $past(pri_hi_w)) else $error("stray high bits");
   a_class_out: assert property (take_w |=>
      primary_class == $past(pri_cls_w)) else $error("class bits wrong");
   a_req_idle: assert property (take_w && io_req_w && io_idle |=>
      io_request && io_start_addr[0] == 1'b0 && !stall)
      else $error("idle request not issued");
   a_busy_stall: assert property (take_w && io_req_w && !io_idle |=>
      stall && !io_request ##0 (stall && !io_request) [*1])
      else $error("busy request not stalled");
   a_done_hold: assert property (r_q.fsm == ST_WAIT_DONE &&
      !sequence_done_flag && !io_idle |=> stall && !addr_valid)
      else $error("wait released early");
   a_done_release: assert property (r_q.fsm == ST_WAIT_DONE &&
      sequence_done_flag |=> !stall && addr_valid ##1 !addr_valid)
      else $error("done did not release");
   a_apb_answer: assert property (apb_req.psel && apb_req.penable &&
      !apb_rsp.pready |=> apb_rsp.pready ##1 !apb_rsp.pready)
      else $error("apb answer timing");

   c_int_path: cover property (take_w && int_pending);
   c_decoded: cover property (addr_valid && addr_path == DAI_PATH_DEC);
   c_busy_req: cover property (r_q.fsm == ST_WAIT_IDLE ##[1:20] io_request);
   c_wait_done: cover property (r_q.fsm == ST_WAIT_DONE ##1 !stall);

endmodule

`default_nettype wire

// ---- rtl/dai_pkg.sv ----
// shared types, constants and default decoder tables for the address decoder
package dai_pkg;

   // ==========================================================
   // widths
   localparam int DAI_IB_W = 16;
   localparam int DAI_ADDR_W = 9;
   localparam int DAI_WORD_W = 16;
   localparam int DAI_DEPTH = 16;

   // ==========================================================
   // apb register map (byte addresses)
   localparam logic [7:0] DAI_OFS_CTRL = 8'h00;
   localparam logic [7:0] DAI_OFS_STATUS = 8'h04;
   localparam logic [7:0] DAI_OFS_LAST = 8'h08;
   localparam logic [1:0] DAI_RGN_REGS = 2'h0;
   localparam logic [1:0] DAI_RGN_PRI = 2'h1;
   localparam logic [1:0] DAI_RGN_SEC = 2'h2;
   localparam int DAI_CTRL_USE_WR = 0;

   // ==========================================================
   // decoder word bit positions
   localparam int PRI_HI_GATE_A = 12;
   localparam int PRI_HI_GATE_B = 15;
   localparam int PRI_LO_GATE = 10;
   localparam int PRI_NIB_HI_N = 14;
   localparam int PRI_NIB_LO_N = 13;
   localparam int PRI_SWAP = 0;
   localparam int SEC_ALT = 13;
   localparam int SEC_SWAP = 9;
   localparam int DAI_CLASS_LSB = 9;

   // ==========================================================
   // microinstruction field codes
   localparam logic [1:0] DAI_TEST_NONE = 2'h0;
   localparam logic [1:0] DAI_SRC_NONE = 2'h0;
   localparam logic [3:0] DAI_MODE_WAIT_DONE = 4'h2;

   // addressing path, one-hot
   localparam logic [2:0] DAI_PATH_FIELD = 3'h1;
   localparam logic [2:0] DAI_PATH_DEC = 3'h2;
   localparam logic [2:0] DAI_PATH_INT = 3'h4;

   typedef enum logic [2:0]
   {
      ST_RUN = 3'b001,
      ST_WAIT_DONE = 3'b010,
      ST_WAIT_IDLE = 3'b100
   } dai_state_t;

   typedef struct packed {
      logic [1:0] sequence_test_field;
      logic [1:0] source_select_field;
      logic [3:0] group_function_field;
      logic [3:0] request_mode_field;
      logic io_start_high_field;
      logic [1:0] io_start_mid_field;
      logic [2:0] io_start_low_field;
      logic branch_field_top_bit;
   } dai_uinstr_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } dai_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } dai_apb_rsp_t;

   // fixed decoder contents; plain default tables
   localparam logic [15:0][15:0] DAI_PRI_ROM = {
      16'hf1e0, 16'hf1c0, 16'hf1a0, 16'hf180,
      16'hf160, 16'hf140, 16'hf120, 16'hf100,
      16'h60e0, 16'h60c0, 16'ha0a0, 16'ha080,
      16'hc060, 16'hc040, 16'he020, 16'hf000};
   localparam logic [15:0][15:0] DAI_SEC_ROM = {
      16'h01f0, 16'h01e0, 16'h01d0, 16'h01c0,
      16'h01b0, 16'h01a0, 16'h0190, 16'h0180,
      16'h2070, 16'h2060, 16'h0250, 16'h0240,
      16'h0030, 16'h0020, 16'h0010, 16'h0000};

   typedef struct packed {
      dai_state_t fsm;
      logic use_wr;
      logic [15:0][15:0] pri_ram;
      logic [15:0][15:0] sec_ram;
      logic [8:0] addr;
      logic [2:0] path;
      logic addr_valid;
      logic io_req;
      logic [7:0] io_start;
      logic stall;
      logic [6:0] pri_class;
      logic [6:0] sec_class;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } dai_regs_t;

   localparam dai_regs_t DAI_REGS_RST = '{
      fsm: ST_RUN,
      pri_ram: DAI_PRI_ROM,
      sec_ram: DAI_SEC_ROM,
      default: '0};

endpackage

// ---- tb/dai_io_seq_model.sv ----
// behavioural model of the i/o control sequencer on the far side
`timescale 1ns/1ps
`default_nettype none

module dai_io_seq_model
   import dai_pkg::*;
#(
   parameter int SEQ_LEN = 6
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic io_request,
   input wire logic [7:0] io_start_addr,
   input wire logic kick,
   output logic io_idle,
   output logic sequence_done_flag,
   output logic [7:0] start_q
);
   logic [15:0] ctrl_q;
   int cnt_q;

   // ==========================================================
   // sequencer
   // busy is the standard code in the control buffer
   assign io_idle = (ctrl_q != 16'h0088);
   // a kick starts a sequence with no request, to make the block wait
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_q <= 16'h0000;
         cnt_q <= 0;
         sequence_done_flag <= 1'b0;
         start_q <= 8'h00;
      end
      else
      begin
         sequence_done_flag <= 1'b0;
         if (!io_idle)
         begin
            if (cnt_q == 0)
            begin
               ctrl_q <= 16'h0000;
               sequence_done_flag <= 1'b1;
            end
            else
               cnt_q <= cnt_q - 1;
         end
         else if (io_request || kick)
         begin
            ctrl_q <= 16'h0088;
            cnt_q <= SEQ_LEN;
            start_q <= io_start_addr;
         end
      end
   end
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the decoded address and i/o request block
`timescale 1ns/1ps
`default_nettype none

module testbench
   import dai_pkg::*;
;
   logic core_clk, reset_n, uinstr_valid, int_pending, kick;
   logic io_idle, sequence_done_flag, addr_valid, io_request, stall;
   logic saw_stall, saw_io, er;
   logic [15:0] instr_buf;
   logic [8:0] decoded_addr;
   logic [2:0] addr_path;
   logic [7:0] io_start_addr, start_q;
   logic [6:0] primary_class, secondary_class;
   logic [31:0] rd;
   dai_apb_req_t apb_req;
   dai_apb_rsp_t apb_rsp;
   dai_uinstr_t uinstr, u;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   localparam dai_uinstr_t DEC_U = '{2'h0, 2'h0, 4'h4, 4'h0, 1'b1, 2'h2,
      3'h5, 1'b1};
   localparam logic [14:0] TBL [7] = '{
      {4'h0, 4'h6, 4'h0, DAI_PATH_DEC}, {4'h0, 4'h3, 4'h0, DAI_PATH_FIELD},
      {4'h4, 4'h4, 4'h0, DAI_PATH_FIELD}, {4'h2, 4'h4, 4'h0, DAI_PATH_FIELD},
      {4'h0, 4'h4, 4'hC, DAI_PATH_FIELD}, {4'h0, 4'h4, 4'hD, DAI_PATH_DEC},
      {4'h0, 4'hF, 4'h8, DAI_PATH_DEC}};

   dai_decoder dai_decoder_i (.core_clk(core_clk), .reset_n(reset_n),
      .apb_req(apb_req), .apb_rsp(apb_rsp), .instr_buf(instr_buf),
      .uinstr(uinstr), .uinstr_valid(uinstr_valid),
      .int_pending(int_pending), .io_idle(io_idle),
      .sequence_done_flag(sequence_done_flag), .decoded_addr(decoded_addr),
      .addr_path(addr_path), .addr_valid(addr_valid),
      .io_request(io_request), .io_start_addr(io_start_addr), .stall(stall),
      .primary_class(primary_class), .secondary_class(secondary_class));
   dai_io_seq_model dai_io_seq_model_i (.core_clk(core_clk),
      .reset_n(reset_n), .io_request(io_request),
      .io_start_addr(io_start_addr), .kick(kick), .io_idle(io_idle),
      .sequence_done_flag(sequence_done_flag), .start_q(start_q));

   // ==========================================================
   // clock and hang guard
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // a hang counts as a mismatch
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         report_and_stop();
      end
   end

   // ==========================================================
   // helpers
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] e,
      input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   // reference address built straight from the component conditions
   function automatic logic [8:0] exp_addr(input logic [15:0] p,
      input logic [15:0] s, input logic [15:0] ib);
      logic [8:0] a;
      logic [3:0] hi;
      logic alt;
      a = p[8:0];
      alt = !p[15] && s[13];
      hi = ib[7:4];
      if (p[0] && s[9])
         hi[2] = ib[3];
      if (!p[12] || !p[15])
         a[8:4] = a[8:4] | s[8:4];
      if (p[10] && (!p[12] || !p[15]))
         a[3:0] = a[3:0] | s[3:0];
      if (!p[14] || alt)
         a[3:0] = a[3:0] | hi;
      if (!p[13] || alt)
         a[3:0] = a[3:0] | ib[3:0];
      return a;
   endfunction
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge core_clk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      // ends once pready is seen high; only the bench timeout ends it if pready never rises
      do
      begin
         @(posedge core_clk);
      end while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   // present one microinstruction and wait for its result
   task automatic run(input dai_uinstr_t x, input logic [15:0] ib);
      int n;
      @(posedge core_clk);
      uinstr <= x;
      instr_buf <= ib;
      uinstr_valid <= 1'b1;
      @(posedge core_clk);
      uinstr_valid <= 1'b0;
      saw_stall = 1'b0;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
         if (stall === 1'b1)
            saw_stall = 1'b1;
      end while (addr_valid !== 1'b1 && n < 200);
      saw_io = (io_request === 1'b1);
      check("addr_valid", 1, addr_valid);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (io_idle !== 1'b1 && n < 100)
      begin
         @(posedge core_clk);
         n++;
      end
   endtask
   task automatic start_busy();
      @(posedge core_clk);
      kick <= 1'b1;
      @(posedge core_clk);
      kick <= 1'b0;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_decode_rom();
      logic [15:0] ib;
      for (int i = 0; i < 16; i++)
      begin
         ib = {i[3:0], ~i[3:0], 8'h5c ^ 8'(i * 37)};
         run(DEC_U, ib);
         check("path", DAI_PATH_DEC, addr_path);
         check("addr", exp_addr(DAI_PRI_ROM[ib[15:12]],
            DAI_SEC_ROM[ib[11:8]], ib), decoded_addr);
         check("pcls", DAI_PRI_ROM[ib[15:12]][15:9], primary_class);
         check("scls", DAI_SEC_ROM[ib[11:8]][15:9], secondary_class);
      end
   endtask
   task automatic t_paths();
      for (int i = 0; i < 7; i++)
      begin
         u = DEC_U;
         {u.sequence_test_field, u.source_select_field} = TBL[i][14:11];
         u.group_function_field = TBL[i][10:7];
         u.request_mode_field = TBL[i][6:3];
         run(u, 16'h9a3c);
         check("path", TBL[i][2:0], addr_path);
      end
      @(posedge core_clk) int_pending <= 1'b1;
      run(DEC_U, 16'h9a3c);
      check("path", DAI_PATH_INT, addr_path);
      u.request_mode_field = 4'hC;
      run(u, 16'h9a3c);
      check("path", DAI_PATH_INT, addr_path);
      @(posedge core_clk) int_pending <= 1'b0;
   endtask
   task automatic t_io();
      u = DEC_U;
      u.request_mode_field = 4'hF;
      run(u, 16'h1234);
      check("io_req", 1, saw_io);
      check("path", DAI_PATH_DEC, addr_path);
      check("start", {u.io_start_high_field, u.io_start_mid_field,
         u.io_start_low_field, u.branch_field_top_bit, 1'b0},
         io_start_addr);
      // let the sequencer take the request before waiting on it
      @(posedge core_clk);
      check("accepted", {u.io_start_high_field, u.io_start_mid_field,
         u.io_start_low_field, u.branch_field_top_bit, 1'b0},
         start_q);
      wait_idle();
      u.request_mode_field = 4'hE;
      u.io_start_low_field = 3'h2;
      run(u, 16'h1234);
      check("io_req", 1, saw_io);
      check("path", DAI_PATH_FIELD, addr_path);
      @(posedge core_clk);
      wait_idle();
      u.source_select_field = 2'h1;
      run(u, 16'h1234);
      check("io_req", 0, saw_io);
   endtask
   task automatic t_io_wait();
      u = DEC_U;
      u.request_mode_field = 4'hF;
      start_busy();
      run(u, 16'h0000);
      check("stall", 1, saw_stall);
      check("io_req", 1, saw_io);
      @(posedge core_clk);
      wait_idle();
      u.request_mode_field = DAI_MODE_WAIT_DONE;
      start_busy();
      run(u, 16'h0000);
      check("stall", 1, saw_stall);
      check("idle", 1, io_idle);
   endtask
   task automatic t_tables();
      apb(0, DAI_OFS_CTRL, 0);
      check("ctrl", 0, rd);
      apb(1, 8'h0C, 1);
      check("err", 1, er);
      apb(0, 8'h02, 0);
      check("err", 1, er);
      apb(1, 8'h4C, 32'hffff_8C01);
      apb(1, 8'h94, 32'h0000_0253);
      apb(0, 8'h4C, 0);
      check("pri3", 32'h0000_8C01, rd);
      apb(1, DAI_OFS_CTRL, 1);
      run(DEC_U, 16'h35b9);
      check("addr", exp_addr(16'h8C01, 16'h0253, 16'h35b9),
         decoded_addr);
      check("pcls", 7'h46, primary_class);
      apb(1, DAI_OFS_CTRL, 0);
      run(DEC_U, 16'h35b9);
      check("addr", exp_addr(DAI_PRI_ROM[3], DAI_SEC_ROM[5], 16'h35b9),
         decoded_addr);
      apb(0, DAI_OFS_LAST, 0);
      check("last", {23'h0, exp_addr(DAI_PRI_ROM[3], DAI_SEC_ROM[5],
         16'h35b9)}, rd);
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      reset_n = 1'b0;
      apb_req = '0;
      uinstr = '0;
      instr_buf = 16'h0000;
      uinstr_valid = 1'b0;
      int_pending = 1'b0;
      kick = 1'b0;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      t_decode_rom();
      t_paths();
      t_io();
      t_io_wait();
      t_tables();
      report_and_stop();
   end
endmodule

`default_nettype wire
